// ### sbtap_core.sv
/*
 * Boundary-scan test port of a double data rate SRAM: controller, instruction
 * and data registers, serial output, and float control of data and echo clock.
 * Assumes the test pins and output enable arrive asynchronously and are
 * sampled on CLK_SYS (test clock far slower); the memory core supplies the
 * ring levels and a flag telling whether its last operation was a read.
 */
`timescale 1ns/100ps
`include "sbtap_map.svh"

// Behaviour
// - sample latches ring levels at capture-dr
// - sample instructions put chain between TDI/TDO
// - float-sample captures ring exactly like sample
// - sample keeps echo clock outputs driven
// - sample leaves data drivers under memory control
// - after power-up/write/deselect data pins float
// - after read, drive data when enable low
// - float-sample floats echo clock and data
// - sixteen states, moves only on rising TCK
// - power-up enters test-logic-reset without TCK
// - five TMS-high rising edges force reset
// - TDI sampled only in shift states
// - TDO driven only in shift states
// - three-bit codes; unknown codes give bypass
// - capture on rising, present on falling
// - chain 68 cells x36, 49 x18
// - identification instruction loaded at reset
module sbtap_core import sbtap_pkg::*; #(
    parameter int BSR_LEN = `SBTAP_BSR_LEN_X36,   // 49 for the 18-bit part
    parameter logic [3:0] ID_REV = 4'h0,          // arbitrary value
    parameter logic [15:0] ID_PART = 16'h1234,    // arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h2AA     // arbitrary value
) (
    input wire logic CLK_SYS,                     // system clock, 25 MHz
    input wire logic RST,                         // synchronous reset, high
    input wire logic TCK,                         // test clock pin
    input wire logic TMS,                         // test mode select pin
    input wire logic TDI,                         // test data in pin
    input wire logic OE_IN_N,                     // memory output enable pin
    input wire logic [BSR_LEN-1:0] RING_IN,       // I/O ring levels
    input wire logic MEM_LAST_READ,               // last memory op was a read
    output logic TDO,                             // test data out
    output logic TDO_OE_N,                        // low while TDO driven
    output logic DQ_OE_N,                         // low while data pins driven
    output logic ECHO_OE_N                        // low while echo_clock_out driven
);

    // ------------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------------
    sbtap_pins_t pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_f_reg;
    logic [BSR_LEN-1:0] ring_s1_reg, ring_s2_reg, ring_s3_reg;
    logic tck_rise, tck_fall, tck_agree;

    // three stages; tck and oe_n levels only count once stages two and three agree
    always_ff @(posedge CLK_SYS) begin
        pin_s1_reg <= '{tck: TCK, tms: TMS, tdi: TDI, oe_n: OE_IN_N};
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        ring_s1_reg <= RING_IN;
        ring_s2_reg <= ring_s1_reg;
        ring_s3_reg <= ring_s2_reg;
    end

    // filtered levels; a one-sample glitch never reaches the tck edges or oe_n, but tms and tdi reach the controller unfiltered from stage three
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pin_f_reg <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, oe_n: 1'b1};
        end else begin
            pin_f_reg <= (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
                       | (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
        end
    end

    assign tck_agree = (pin_s2_reg.tck == pin_s3_reg.tck);
    assign tck_rise = tck_agree && pin_s3_reg.tck && !pin_f_reg.tck;
    assign tck_fall = tck_agree && !pin_s3_reg.tck && pin_f_reg.tck;

    // ------------------------------------------------------------------
    // controller
    // ------------------------------------------------------------------
    sbtap_state_t state_reg, state_next;

    function automatic sbtap_state_t tap_next(input sbtap_state_t s, input logic m);
        unique case (s)
            ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
            ST_IDLE:  tap_next = m ? ST_SELDR : ST_IDLE;
            ST_SELDR: tap_next = m ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: tap_next = m ? ST_EX1DR : ST_SHDR;
            ST_SHDR:  tap_next = m ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: tap_next = m ? ST_UPDR : ST_PADR;
            ST_PADR:  tap_next = m ? ST_EX2DR : ST_PADR;
            ST_EX2DR: tap_next = m ? ST_UPDR : ST_SHDR;
            ST_UPDR:  tap_next = m ? ST_SELDR : ST_IDLE;
            ST_SELIR: tap_next = m ? ST_RESET : ST_CAPIR;
            ST_CAPIR: tap_next = m ? ST_EX1IR : ST_SHIR;
            ST_SHIR:  tap_next = m ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: tap_next = m ? ST_UPIR : ST_PAIR;
            ST_PAIR:  tap_next = m ? ST_EX2IR : ST_PAIR;
            ST_EX2IR: tap_next = m ? ST_UPIR : ST_SHIR;
            ST_UPIR:  tap_next = m ? ST_SELDR : ST_IDLE;
        endcase
    endfunction : tap_next

    assign state_next = tap_next(state_reg, pin_s3_reg.tms);

    // power-up reset needs no test clock at all
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_reg <= ST_RESET;
        end else if (tck_rise) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------
    logic [`SBTAP_IR_W-1:0] ir_reg, ir_sh_reg;
    logic sel_bsr, sel_id, in_shift;

    // private code behaves as bypass so it can never reach hidden logic
    function automatic logic [1:0] decode_ir(input logic [`SBTAP_IR_W-1:0] c);
        unique case (c)
            `SBTAP_IR_IDCODE: decode_ir = 2'h1;
            `SBTAP_IR_SAMPLE, `SBTAP_IR_SAMPZ: decode_ir = 2'h2;
            default: decode_ir = 2'h0;
        endcase
    endfunction : decode_ir

    assign sel_id = (decode_ir(ir_reg) == 2'h1);
    assign sel_bsr = (decode_ir(ir_reg) == 2'h2);
    assign in_shift = (state_reg == ST_SHIR) || (state_reg == ST_SHDR);

    // shift into the msb, lsb leaves first; executes only at update
    // reset state reloads the id code without waiting for a test clock,
    // so a parked controller can never leave the outputs floated
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ir_reg <= `SBTAP_IR_IDCODE;
            ir_sh_reg <= `SBTAP_IR_IDCODE;
        end else if (state_reg == ST_RESET) begin
            ir_reg <= `SBTAP_IR_IDCODE;
        end else if (tck_rise) begin
            unique case (state_reg)
                ST_CAPIR: ir_sh_reg <= `SBTAP_IR_IDCODE;
                ST_SHIR:  ir_sh_reg <= {pin_s3_reg.tdi, ir_sh_reg[`SBTAP_IR_W-1:1]};
                ST_UPIR:  ir_reg <= ir_sh_reg;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------------
    logic [BSR_LEN-1:0] bsr_reg;
    logic [`SBTAP_ID_W-1:0] id_reg;
    logic byp_reg;

    // capture on the rising edge, shift only in shift-dr
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            bsr_reg <= '0;
            id_reg <= '0;
            byp_reg <= `SBTAP_BYPASS_CAPT;
        end else if (tck_rise && state_reg == ST_CAPDR) begin
            if (sel_bsr) begin
                bsr_reg <= ring_s3_reg;
            end
            id_reg <= {ID_REV, ID_PART, ID_MAKER, `SBTAP_ID_START_BIT};
            byp_reg <= `SBTAP_BYPASS_CAPT;
        end else if (tck_rise && state_reg == ST_SHDR) begin
            if (sel_bsr) begin
                bsr_reg <= {pin_s3_reg.tdi, bsr_reg[BSR_LEN-1:1]};
            end
            id_reg <= {1'b0, id_reg[`SBTAP_ID_W-1:1]};          // read-only, no tdi
            byp_reg <= pin_s3_reg.tdi;
        end
    end

    // ------------------------------------------------------------------
    // serial output, changed on the falling edge
    // ------------------------------------------------------------------
    logic tdo_next;

    // mux chosen from the current state, which is steady at the fall
    always_comb begin
        if (state_reg == ST_SHIR) begin
            tdo_next = ir_sh_reg[0];
        end else if (sel_bsr) begin
            tdo_next = bsr_reg[0];
        end else if (sel_id) begin
            tdo_next = id_reg[0];
        end else begin
            tdo_next = byp_reg;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            TDO <= 1'b0;
            TDO_OE_N <= 1'b1;
        end else if (tck_fall) begin
            TDO <= tdo_next;
            TDO_OE_N <= !in_shift;
        end
    end

    // ------------------------------------------------------------------
    // memory output float control
    // ------------------------------------------------------------------
    // sample-z floats everything; otherwise normal read-and-enable rule
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            DQ_OE_N <= 1'b1;
            ECHO_OE_N <= 1'b0;
        end else begin
            ECHO_OE_N <= (ir_reg == `SBTAP_IR_SAMPZ);
            DQ_OE_N <= (ir_reg == `SBTAP_IR_SAMPZ)
                     || !MEM_LAST_READ || pin_f_reg.oe_n;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [2:0] tms_run_reg;

    // consecutive rising edges seen with TMS high, saturating
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            tms_run_reg <= 3'h0;
        end else if (tck_rise) begin
            tms_run_reg <= !pin_s3_reg.tms ? 3'h0
                         : (tms_run_reg == 3'h7) ? 3'h7 : tms_run_reg + 3'h1;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_tms_reset_run: assert property (tms_run_reg >= `SBTAP_TMS_RESET_EDGES
        |-> state_reg == ST_RESET) else $error("five TMS-high edges did not reset");
    a_state_rise_only: assert property (!tck_rise |=> $stable(state_reg))
        else $error("state moved without a rising test clock");
    a_reset_load_id: assert property (state_reg == ST_RESET
        |=> ir_reg == `SBTAP_IR_IDCODE) else $error("reset did not load id code");
    a_tdo_oe_shift: assert property (tck_fall |=> TDO_OE_N == !in_shift)
        else $error("tdo enable wrong for state");
    a_bsr_capture: assert property (tck_rise && state_reg == ST_CAPDR && sel_bsr
        |=> bsr_reg == $past(ring_s3_reg)) else $error("ring not captured");
    a_bsr_shift_path: assert property (tck_rise && state_reg == ST_SHDR && sel_bsr
        |=> bsr_reg[0] == $past(bsr_reg[1]) && bsr_reg[BSR_LEN-1] == $past(pin_s3_reg.tdi))
        else $error("chain did not shift");
    a_tdi_ignored: assert property (tck_rise && !in_shift && state_reg != ST_CAPDR
        |=> $stable(bsr_reg)) else $error("tdi taken outside shift");
    a_float_outputs: assert property (ir_reg == `SBTAP_IR_SAMPZ
        |=> DQ_OE_N && ECHO_OE_N) else $error("outputs not floated");
    a_sample_echo_on: assert property (ir_reg == `SBTAP_IR_SAMPLE |=> !ECHO_OE_N)
        else $error("echo clock floated in sample");
    a_sample_dq_read: assert property (ir_reg == `SBTAP_IR_SAMPLE && MEM_LAST_READ
        && !pin_f_reg.oe_n |=> !DQ_OE_N) else $error("read data not driven");
    a_sample_dq_idle: assert property (ir_reg == `SBTAP_IR_SAMPLE && !MEM_LAST_READ
        |=> DQ_OE_N) else $error("data driven after non-read");

    c_sample_capture: cover property (tck_rise && state_reg == ST_CAPDR
        && ir_reg == `SBTAP_IR_SAMPLE);
    c_sampz_float: cover property (ir_reg == `SBTAP_IR_SAMPZ ##1 DQ_OE_N && ECHO_OE_N);
    c_ir_update: cover property (tck_rise && state_reg == ST_UPIR);

endmodule : sbtap_core

// ### sbtap_core_tb_top.sv
/*
 * Self-checking bench of the test port: instruction table loop, then output-enable,
 * forced-reset and reset cases.
 * Assumes sbtap_core, sbtap_pkg and the controller model are compiled before it.
 */
`timescale 1ns/100ps
`include "sbtap_map.svh"
module sbtap_core_tb_top import sbtap_pkg::*;;
    localparam int BLEN = `SBTAP_BSR_LEN_X18;
    localparam logic [31:0] ID_EXP = {4'h3, 16'hBEEF, 11'h155, 1'h1}; // arbitrary fields
    localparam logic [63:0] TDI_PAT = 64'hC3A5_96F0_0F69_5A3C;
    localparam logic [BLEN-1:0] RING_PAT = 49'h1_2345_6789_ABCD;
    logic clk_sys, rst, tck, tms, tdi, oe_in_n, mem_last_read;
    logic [BLEN-1:0] ring_in;
    logic tdo, tdo_oe_n, dq_oe_n, echo_oe_n;
    int errors, tests_run;
    // rows: code, chain kind (0 bypass, 1 id, 2 ring), dq_oe_n, echo_oe_n
    logic [6:0] rows [8] = '{7'h00, 7'h14, 7'h2B, 7'h30, 7'h48, 7'h50, 7'h60, 7'h70};

    always #20 clk_sys = ~clk_sys;

    sbtap_core #(.BSR_LEN(BLEN), .ID_REV(4'h3), .ID_PART(16'hBEEF), .ID_MAKER(11'h155)) u_dut (
        .CLK_SYS(clk_sys), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi), .OE_IN_N(oe_in_n),
        .RING_IN(ring_in), .MEM_LAST_READ(mem_last_read), .TDO(tdo), .TDO_OE_N(tdo_oe_n),
        .DQ_OE_N(dq_oe_n), .ECHO_OE_N(echo_oe_n));
    sbtap_ctl_model u_ctl (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // tms bits taken from pat, lsb first, no shifting
    task automatic walk(input logic [7:0] pat, input int n);
        logic d, o;
        for (int i = 0; i < n; i++) begin
            u_ctl.step(pat[i], 1'b0, 1'b0, d, o);
        end
    endtask : walk

    // from idle: load a code, read back the captured value
    task automatic load_ir(input logic [2:0] code);
        logic [2:0] cap;
        logic o;
        walk(8'h03, 4);
        for (int i = 0; i < 3; i++) begin
            u_ctl.step(i == 2, 1'b1, code[i], cap[i], o);
            chk(o, 1'h0);
        end
        chk(cap, 3'h1);
        walk(8'h01, 2);
    endtask : load_ir

    // from idle: capture, shift 60 bits, back to idle
    task automatic run_dr(input int kind);
        logic [63:0] got, exp;
        logic d, o, oes;
        oes = 1'b0;
        walk(8'h01, 3);
        for (int i = 0; i < 60; i++) begin
            u_ctl.step(i == 59, 1'b1, TDI_PAT[i], d, o);
            got[i] = d;
            oes = oes | o;
        end
        walk(8'h01, 2);
        for (int i = 0; i < 60; i++) begin
            if (kind == 0) exp[i] = (i == 0) ? 1'b0 : TDI_PAT[(i > 0) ? i - 1 : 0];
            else if (kind == 1) exp[i] = (i < 32) ? ID_EXP[i] : 1'b0;
            else exp[i] = (i < BLEN) ? ring_in[i] : TDI_PAT[(i >= BLEN) ? i - BLEN : 0];
        end
        for (int i = 60; i < 64; i++) begin
            exp[i] = 1'b0;
            got[i] = 1'b0;
        end
        chk(got, exp);
        chk(oes, 1'h0);
        chk(tdo_oe_n, 1'h1);
    endtask : run_dr

    task automatic test_done;
        $display("tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        oe_in_n = 1'b0;
        mem_last_read = 1'b0;
        ring_in = RING_PAT;
        errors = 0;
        tests_run = 0;
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk({tdo, tdo_oe_n, dq_oe_n, echo_oe_n}, 4'h6);
        repeat (4) @(posedge clk_sys);
        walk(8'h00, 1);
        run_dr(1);
        mem_last_read = 1'b1;
        // every code, reserved one included; ring flips so a stale capture shows
        for (int r = 0; r < 8; r++) begin
            ring_in = RING_PAT ^ {BLEN{r[0]}};
            load_ir(rows[r][6:4]);
            repeat (6) @(posedge clk_sys);
            #1;
            chk({dq_oe_n, echo_oe_n}, rows[r][1:0]);
            run_dr(rows[r][3:2]);
        end
        // sample: drivers follow enable and last operation only
        load_ir(3'h4);
        oe_in_n = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        chk({dq_oe_n, echo_oe_n}, 2'h2);
        oe_in_n = 1'b0;
        mem_last_read = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        chk({dq_oe_n, echo_oe_n}, 2'h2);
        mem_last_read = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        chk({dq_oe_n, echo_oe_n}, 2'h0);
        // five tms-high edges from mid shift-dr force reset and id code;
        // float-sample is loaded so the release of the outputs shows at once
        load_ir(3'h2);
        walk(8'h01, 3);
        walk(8'h1F, 5);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({dq_oe_n, echo_oe_n}, 2'h0);
        walk(8'h00, 1);
        run_dr(1);
        // reset in mid-run with the outputs floated
        load_ir(3'h2);
        rst = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk({tdo, tdo_oe_n, dq_oe_n, echo_oe_n}, 4'h6);
        walk(8'h00, 1);
        run_dr(1);
        test_done();
    end

    // watchdog: whole run needs well under 1 ms
    initial begin
        #2000000;
        errors++;
        test_done();
    end
endmodule : sbtap_core_tb_top

// ### sbtap_ctl_model.sv
/*
 * Behavioural boundary-scan test controller that drives the test port pins.
 * Assumes a free-running clk_sys is given for pacing; tck stands still low between steps.
 */
`timescale 1ns/100ps
module sbtap_ctl_model (
    input wire logic clk_sys,   // pacing clock, 40 ns
    output logic tck,           // test clock, 320 ns per step
    output logic tms,           // mode select
    output logic tdi,           // serial data to the port
    input wire logic tdo,       // serial data from the port
    input wire logic tdo_oe_n   // low while the port drives tdo
);
    // ------------------------------------------------------------------
    // pin levels and the single tck step
    // ------------------------------------------------------------------
    // idle levels at time zero
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // 4 cycles low then 4 high; tdo read just before the rise
    // off shift, tdi flips each step, so a port that read it would go wrong
    // tms held across the rise, states walked as the standard graph has them
    task automatic step(input logic tms_i, input logic sh, input logic tdi_i,
                        output logic tdo_o, output logic oe_o);
        @(posedge clk_sys);
        #1;
        tms = tms_i;
        tdi = sh ? tdi_i : ~tdi;
        repeat (3) @(posedge clk_sys);
        #1;
        tdo_o = tdo;
        oe_o = tdo_oe_n;
        tck = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        tck = 1'b0;
    endtask : step
endmodule : sbtap_ctl_model

// ### sbtap_map.svh
/*
 * Offsets, codes, lengths and reset values of the boundary-scan test port.
 * Assumes inclusion by sbtap_pkg and by the core; definitions only.
 */
`ifndef SBTAP_MAP_SVH
`define SBTAP_MAP_SVH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define SBTAP_IR_W 3
`define SBTAP_IR_BYPASS 3'h0
`define SBTAP_IR_IDCODE 3'h1
`define SBTAP_IR_SAMPZ 3'h2
`define SBTAP_IR_SAMPLE 3'h4
`define SBTAP_IR_PRIVATE 3'h5

// ----------------------------------------------------------------------
// data registers
// ----------------------------------------------------------------------
`define SBTAP_ID_W 32
`define SBTAP_BSR_LEN_X36 68
`define SBTAP_BSR_LEN_X18 49
`define SBTAP_BYPASS_CAPT 1'h0
`define SBTAP_ID_START_POS 0
`define SBTAP_ID_START_BIT 1'h1
`define SBTAP_TMS_RESET_EDGES 3'h5

// ----------------------------------------------------------------------
// pin synchroniser
// ----------------------------------------------------------------------
`define SBTAP_SYNC_STAGES 3

`endif

// ### sbtap_pkg.sv
/*
 * Types of the boundary-scan test port: controller states, pin bundle.
 * Assumes sbtap_map.svh is on the include path.
 */
`include "sbtap_map.svh"

package sbtap_pkg;

    // ------------------------------------------------------------------
    // controller states, gray steps along the usual walk
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET  = 4'h0,
        ST_IDLE   = 4'h1,
        ST_SELDR  = 4'h3,
        ST_CAPDR  = 4'h2,
        ST_SHDR   = 4'h6,
        ST_EX1DR  = 4'h7,
        ST_PADR   = 4'h5,
        ST_EX2DR  = 4'h4,
        ST_UPDR   = 4'hC,
        ST_SELIR  = 4'hD,
        ST_CAPIR  = 4'hF,
        ST_SHIR   = 4'hE,
        ST_EX1IR  = 4'hA,
        ST_PAIR   = 4'hB,
        ST_EX2IR  = 4'h9,
        ST_UPIR   = 4'h8
    } sbtap_state_t;

    // test pins plus the asynchronous output enable, sampled together
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic oe_n;
    } sbtap_pins_t;

endpackage : sbtap_pkg
